/* File: inc/txc_cfg.svh */
// register map, field positions, reset values and polynomials of the transmit checksum generator
`ifndef TXC_CFG_SVH
`define TXC_CFG_SVH
`define TXC_ADDR_W 10
`define TXC_CFG_IDX 8'h19
`define TXC_STAT_IDX 8'h20
`define TXC_CFG_ADDR {`TXC_CFG_IDX, 2'b00}
`define TXC_STAT_ADDR {`TXC_STAT_IDX, 2'b00}
`define TXC_CFG_RST 32'h0000_0000
`define TXC_CFG_WMASK 32'hFFFF_007F
`define TXC_F_PRESET_HI 31
`define TXC_F_PRESET_LO 16
`define TXC_F_SKIP 6
`define TXC_F_SEL_HI 5
`define TXC_F_SEL_LO 3
`define TXC_F_NARROW 2
`define TXC_F_INV 1
`define TXC_F_EN 0
`define TXC_PRE_000 16'h0000
`define TXC_PRE_001 16'h6363
`define TXC_PRE_010 16'hA671
`define TXC_PRE_011 16'hFFFF
`define TXC_PRE_100 16'h0012
`define TXC_PRE_101 16'hE012
`define TXC_POLY16_REFL 16'h8408
`define TXC_POLY5_REFL 5'h12
`define TXC_FIFO_W 9
`define TXC_FIFO_D 8
`endif

/* File: inc/txc_pkg.sv */
// types of the transmit checksum generator
package txc_pkg;
  typedef enum logic [2:0] {
    ST_DATA = 3'b001,
    ST_CRC0 = 3'b010,
    ST_CRC1 = 3'b100
  } txc_state_t;
  typedef enum logic [2:0] {
    SEL_ZERO = 3'b000,
    SEL_6363 = 3'b001,
    SEL_A671 = 3'b010,
    SEL_FFFF = 3'b011,
    SEL_0012 = 3'b100,
    SEL_E012 = 3'b101,
    SEL_RSVD = 3'b110,
    SEL_CUSTOM = 3'b111
  } txc_sel_t;
endpackage

/* File: hdl/txc_fifo.sv */
// byte fifo in front of the checksum generator
`timescale 1ns/1ps
module txc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic full_r;
  logic empty_r;
  logic push;
  logic pop;

  assign push = in_valid && !full_r;
  assign pop = out_ready && !empty_r;
  assign in_ready = !full_r;
  assign out_valid = !empty_r;
  assign out_data = mem_r[rd_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      full_r <= 1'b0;
      empty_r <= 1'b1;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
        full_r <= (cnt_r == (AW+1)'(DEPTH - 1));
        empty_r <= 1'b0;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
        full_r <= 1'b0;
        empty_r <= (cnt_r == (AW+1)'(1));
      end
    end
  end
endmodule // txc_fifo

/* File: hdl/txc_crc_step.sv */
// one byte of checksum update, lsb first, 16-bit or 5-bit register
`timescale 1ns/1ps
`include "txc_cfg.svh"
module txc_crc_step (
  // current value and byte
  input wire logic [15:0] crc_in,
  input wire logic [7:0] data,
  input wire logic narrow,
  // updated value
  output logic [15:0] crc_out
);
  logic [15:0] c16 [9];
  logic [4:0] c5 [9];

  assign c16[0] = crc_in;
  assign c5[0] = crc_in[4:0];

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      logic fb16;
      logic fb5;
      assign fb16 = c16[i][0] ^ data[i];
      assign fb5 = c5[i][0] ^ data[i];
      assign c16[i+1] = (c16[i] >> 1) ^ (fb16 ? `TXC_POLY16_REFL : 16'h0000);
      assign c5[i+1] = (c5[i] >> 1) ^ (fb5 ? `TXC_POLY5_REFL : 5'h00);
    end
  endgenerate

  assign crc_out = narrow ? {11'h000, c5[8]} : c16[8];
endmodule // txc_crc_step

/* File: hdl/txc_gen.sv */
// transmit checksum generator with apb configuration register and byte stream path
`timescale 1ns/1ps
`include "txc_cfg.svh"
// How it works
// - selector 111b seeds the checksum from the custom value in config bits 31:16.
// - with skip set, the first frame byte passes but is not checksummed.
// - selector codes 000b-101b pick 0000h, 6363h, A671h, FFFFh, 0012h, E012h.
// - in 5-bit mode only the low five bits of the chosen seed are used.
// - width bit 0 gives a 16-bit checksum, 1 a 5-bit one; reset is 0.
// - invert bit 1 sends the complement of the checksum; reset sends it plain.
// - only with enable set is a checksum computed and appended; reset is off.
module txc_gen
  import txc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TXC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // frame bytes in
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  output logic in_ready,
  // frame bytes out, checksum appended
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  input wire logic out_ready
);
  logic [31:0] cfg_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [7:0] out_data_r;
  logic out_valid_r;
  logic out_last_r;
  logic in_ready_r;
  txc_state_t state_r;
  logic [15:0] crc_r;
  logic first_r;
  logic [7:0] byte_cnt_r;
  logic [7:0] frame_cnt_r;
  logic rsvd_seen_r;

  logic acc;
  logic done;
  logic bad_acc;
  logic wr_cfg;
  logic hit_cfg;
  logic hit_stat;
  logic [15:0] preset;
  logic [15:0] seed;
  logic [15:0] crc_base;
  logic [15:0] crc_next;
  logic [15:0] crc_tx;
  logic [7:0] crc_lo;
  logic [7:0] crc_hi;
  logic slot_free;
  logic f_ready;
  logic f_valid;
  logic [8:0] f_data;
  logic f_in_ready;
  logic take;
  logic skip_now;
  logic f_in_valid;
  logic [8:0] f_in_data;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  logic en_bit;
  logic inv_bit;
  logic narrow_bit;
  logic skip_bit;
  txc_sel_t sel;

  assign en_bit = cfg_r[`TXC_F_EN];
  assign inv_bit = cfg_r[`TXC_F_INV];
  assign narrow_bit = cfg_r[`TXC_F_NARROW];
  assign skip_bit = cfg_r[`TXC_F_SKIP];
  assign sel = txc_sel_t'(cfg_r[`TXC_F_SEL_HI:`TXC_F_SEL_LO]);

  // register decode
  assign acc = psel && penable && !pready_r;
  assign done = psel && penable && pready_r;
  assign hit_cfg = (paddr == `TXC_CFG_ADDR);
  assign hit_stat = (paddr == `TXC_STAT_ADDR);
  assign bad_acc = !hit_cfg && !(hit_stat && !pwrite);
  // a write lands at the edge that completes the transfer
  assign wr_cfg = done && pwrite && hit_cfg;

  // status word: checksum, frame count, byte count, reserved flag, state
  assign status_word = {
    crc_r,
    frame_cnt_r,
    byte_cnt_r[3:0],
    rsvd_seen_r,
    state_r
  };

  // read data for the addressed register
  always_comb begin
    rd_word = 32'h0000_0000;
    if (!pwrite && hit_cfg) begin
      rd_word = cfg_r;
    end else if (!pwrite && hit_stat) begin
      rd_word = status_word;
    end
  end

  // apb answer: one wait cycle, then pready for one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= acc;
      pslverr_r <= acc && bad_acc;
      if (acc) begin
        prdata_r <= rd_word;
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  // configuration register, reserved bits stay zero
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= `TXC_CFG_RST;
    end else if (wr_cfg) begin
      cfg_r <= pwdata & `TXC_CFG_WMASK;
    end
  end

  // seed selection
  always_comb begin
    unique case (sel)
      SEL_ZERO: preset = `TXC_PRE_000;
      SEL_6363: preset = `TXC_PRE_001;
      SEL_A671: preset = `TXC_PRE_010;
      SEL_FFFF: preset = `TXC_PRE_011;
      SEL_0012: preset = `TXC_PRE_100;
      SEL_E012: preset = `TXC_PRE_101;
      SEL_RSVD: preset = `TXC_PRE_000;
      SEL_CUSTOM: preset = cfg_r[`TXC_F_PRESET_HI:`TXC_F_PRESET_LO];
    endcase
  end

  assign seed = narrow_bit ? {11'h000, preset[4:0]} : preset;

  assign f_in_valid = in_valid && in_ready_r;
  assign f_in_data = {in_last, in_data};

  // byte path
  txc_fifo #(
    .WIDTH(`TXC_FIFO_W),
    .DEPTH(`TXC_FIFO_D)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(f_in_valid),
    .in_data(f_in_data),
    .in_ready(f_in_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_ready)
  );

  assign slot_free = !out_valid_r || out_ready;
  assign f_ready = (state_r == ST_DATA) && slot_free;
  assign take = f_ready && f_valid;
  assign skip_now = first_r && skip_bit;
  assign crc_base = first_r ? seed : crc_r;

  txc_crc_step u_step (
    .crc_in(crc_base),
    .data(f_data[7:0]),
    .narrow(narrow_bit),
    .crc_out(crc_next)
  );

  assign crc_tx = inv_bit ? ~crc_r : crc_r;
  assign crc_lo = narrow_bit ? {3'b000, crc_tx[4:0]} : crc_tx[7:0];
  assign crc_hi = crc_tx[15:8];

  // fill-side ready registered from fifo state
  always_ff @(posedge clk) begin
    if (rst) begin
      in_ready_r <= 1'b0;
    end else begin
      in_ready_r <= f_in_ready && !(in_valid && in_ready_r && f_in_ready && !take);
    end
  end

  // checksum accumulation
  always_ff @(posedge clk) begin
    if (rst) begin
      crc_r <= 16'h0000;
    end else if (take && en_bit) begin
      crc_r <= skip_now ? seed : crc_next;
    end
  end

  // frame tracking and counters
  always_ff @(posedge clk) begin
    if (rst) begin
      first_r <= 1'b1;
      byte_cnt_r <= 8'h00;
      frame_cnt_r <= 8'h00;
    end else if (take) begin
      first_r <= f_data[8];
      if (first_r) begin
        byte_cnt_r <= (skip_now || !en_bit) ? 8'h00 : 8'h01;
      end else if (en_bit) begin
        byte_cnt_r <= byte_cnt_r + 8'h01;
      end
      if (f_data[8]) begin
        frame_cnt_r <= frame_cnt_r + 8'h01;
      end
    end
  end

  // reserved selector seen during a frame
  always_ff @(posedge clk) begin
    if (rst) begin
      rsvd_seen_r <= 1'b0;
    end else if (take && (sel == SEL_RSVD)) begin
      rsvd_seen_r <= 1'b1;
    end else if (wr_cfg) begin
      rsvd_seen_r <= 1'b0;
    end
  end

  // sequencer state: data bytes, then checksum bytes low first
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_DATA;
    end else begin
      unique case (state_r)
        ST_DATA: begin
          if (take && f_data[8] && en_bit) begin
            state_r <= ST_CRC0;
          end
        end
        ST_CRC0: begin
          if (slot_free) begin
            state_r <= narrow_bit ? ST_DATA : ST_CRC1;
          end
        end
        ST_CRC1: begin
          if (slot_free) begin
            state_r <= ST_DATA;
          end
        end
      endcase
    end
  end

  // output register, held until the consumer takes it
  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid_r <= 1'b0;
      out_data_r <= 8'h00;
      out_last_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_DATA: begin
          if (take) begin
            out_valid_r <= 1'b1;
            out_data_r <= f_data[7:0];
            out_last_r <= f_data[8] && !en_bit;
          end else if (out_ready) begin
            out_valid_r <= 1'b0;
          end
        end
        ST_CRC0: begin
          if (slot_free) begin
            out_valid_r <= 1'b1;
            out_data_r <= crc_lo;
            out_last_r <= narrow_bit;
          end
        end
        ST_CRC1: begin
          if (slot_free) begin
            out_valid_r <= 1'b1;
            out_data_r <= crc_hi;
            out_last_r <= 1'b1;
          end
        end
      endcase
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign in_ready = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data = out_data_r;
  assign out_last = out_last_r;
endmodule // txc_gen

/* File: bench/txc_gen_asserts.sv */
// port checker of the transmit checksum generator
`timescale 1ns/1ps
`include "txc_cfg.svh"
module txc_gen_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TXC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // stream
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic out_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic acc;
  logic [31:0] cfg_r;
  assign acc = psel && penable && !pready;
  // shadow of the config word for stream checks
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= 32'h0;
    end else if (psel && penable && pready && pwrite && paddr == `TXC_CFG_ADDR) begin
      cfg_r <= pwdata;
    end
  end
  ready_next_a: assert property (acc |=> pready) else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  unmapped_err_a: assert property (acc && paddr != `TXC_CFG_ADDR && paddr != `TXC_STAT_ADDR |=> pslverr)
    else $error("unmapped not refused");
  status_wr_a: assert property (acc && pwrite && paddr == `TXC_STAT_ADDR |=> pslverr)
    else $error("status write not refused");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last))
    else $error("output dropped under stall");
  reset_idle_a: assert property ($fell(rst) |-> !out_valid && !pready && !in_ready)
    else $error("outputs busy after reset");
  narrow_pad_a: assert property (out_valid && out_last && cfg_r[0] && cfg_r[2] |-> out_data[7:5] == 3'h0)
    else $error("short checksum byte padded wrong");
  cover property (acc && pwrite);
  cover property (pslverr);
  cover property (out_valid && out_last && cfg_r[0]);
endmodule // txc_gen_chk
bind txc_gen txc_gen_chk u_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .in_ready, .out_valid, .out_data, .out_last, .out_ready);

/* File: bench/txc_sink.sv */
// encoder model taking framed bytes, prompt or stalling
`timescale 1ns/1ps
module txc_sink (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pace
  input wire logic slow,
  // byte stream
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  output logic out_ready
);
  logic [8:0] got[$];
  logic [2:0] cnt;
  // slow pace takes one byte in four cycles
  always @(posedge clk) begin
    if (rst) begin
      cnt <= 3'h0;
      out_ready <= 1'b0;
    end else begin
      cnt <= cnt + 3'h1;
      out_ready <= !slow || cnt[1:0] == 2'h3;
      if (out_valid && out_ready) got.push_back({out_last, out_data});
    end
  end
endmodule // txc_sink

/* File: bench/tb_txc_gen.sv */
// self-checking bench of the transmit checksum generator
`timescale 1ns/1ps
`include "txc_cfg.svh"
module tb_txc_gen;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`TXC_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic in_valid = 1'b0;
  logic in_last = 1'b0;
  logic slow = 1'b0;
  logic [7:0] in_data = 8'h0;
  logic in_ready;
  logic out_valid;
  logic out_last;
  logic out_ready;
  logic [7:0] out_data;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] seed = 32'd81206;
  logic [31:0] rd;
  logic [31:0] cfg;
  logic er;
  logic [8:0] exp_q[$];
  logic [15:0] pre[8] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF, 16'h0012, 16'hE012, 16'h0000, 16'h0000};
  txc_gen dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .in_valid, .in_data, .in_last, .in_ready, .out_valid, .out_data, .out_last, .out_ready);
  txc_sink sink (.clk, .rst, .slow, .out_valid, .out_data, .out_last, .out_ready);
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // one bit of the lsb-first checksum
  function automatic logic [15:0] step(logic [15:0] c, logic d, logic nw);
    logic fb;
    fb = c[0] ^ d;
    c = c >> 1;
    if (fb) c ^= nw ? 16'h0012 : 16'h8408;
    return c;
  endfunction
  task automatic results();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(logic wr, logic [9:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic put(logic [7:0] b, logic l);
    in_valid <= 1'b1;
    in_data <= b;
    in_last <= l;
    @(posedge clk);
    while (in_ready !== 1'b1) @(posedge clk);
  endtask
  // sends one frame and compares the stream with the model
  task automatic frame(logic [31:0] f, int n);
    logic [15:0] c;
    logic [7:0] b;
    c = f[5:3] == 3'h7 ? f[31:16] : pre[f[5:3]];
    if (f[2]) c = {11'h0, c[4:0]};
    for (int i = 0; i < n; i++) begin
      b = 8'(rnd());
      exp_q.push_back({!f[0] && i == n - 1, b});
      if (!(f[6] && i == 0)) for (int k = 0; k < 8; k++) c = step(c, b[k], f[2]);
      put(b, i == n - 1);
    end
    in_valid <= 1'b0;
    if (f[1]) c = ~c;
    if (f[0] && f[2]) exp_q.push_back({4'h8, c[4:0]});
    if (f[0] && !f[2]) begin
      exp_q.push_back({1'b0, c[7:0]});
      exp_q.push_back({1'b1, c[15:8]});
    end
    while (sink.got.size() < exp_q.size()) @(posedge clk);
    repeat (8) @(posedge clk);
    chk("byte count", exp_q.size(), sink.got.size());
    foreach (exp_q[i]) chk("out byte", 32'(exp_q[i]), 32'(sink.got[i]));
    exp_q.delete();
    sink.got.delete();
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `TXC_CFG_ADDR, 32'h0);
    chk("cfg reset", 32'h0, rd);
    apb(1'b1, `TXC_STAT_ADDR, 32'h1);
    chk("status write err", 32'h1, 32'(er));
    apb(1'b0, 10'h3F0, 32'h0);
    chk("unmapped err", 32'h1, 32'(er));
    chk("unmapped data", 32'h0, rd);
    frame(32'h0, 3);
    for (int t = 0; t < 24; t++) begin
      cfg = rnd() & 32'hFFFF_007F;
      cfg[5:3] = 3'(t);
      cfg[0] = (t % 6) != 5;
      slow <= t[1];
      apb(1'b1, `TXC_CFG_ADDR, cfg);
      apb(1'b0, `TXC_CFG_ADDR, 32'h0);
      chk("cfg readback", cfg, rd);
      chk("cfg error", 32'h0, 32'(er));
      frame(cfg, 1 + int'(rnd() % 16));
    end
    apb(1'b0, `TXC_STAT_ADDR, 32'h0);
    chk("status low half", 32'h0000_1901, rd & 32'h0000_FFFF);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `TXC_CFG_ADDR, 32'h0);
    chk("cfg after reset", 32'h0, rd);
    results();
  end
endmodule // tb_txc_gen
